// ==== include/adc_readout_pkg.sv ====
// adc_readout_pkg: constants for the adc channel readout block
// assumes an apb master with 32-bit data and a 10 MHz clock
// Notes on behaviour
// - twelve inputs, gain bits in two registers
// - gain 0 unity, gain 1 times ten
// - channel 22 only when supply enable set
// - channel 24 only when charge enable set
// - charge current as two's complement code
// - channel 25 only when backup enable set
// - backup cell straight binary, two thirds scale
// - battery detect channel 26 needs enable
// - bias bits held inside eight slots, one picked by the channel select register
// - pen touch sets flag, unmasked raises irq
// - position reads give ten-bit coordinate
// - contact reading is drop times two
// - integrator results step sixteen-bit count
// - pen flag is bit 1 at 0x5F
package adc_readout_pkg;
    localparam int ADDR_W = 12;
    // register indices; the byte address is four times the index
    localparam logic [7:0] IDX_CTRL_ONE  = 8'h50;
    localparam logic [7:0] IDX_CTRL_THREE = 8'h52;
    localparam logic [7:0] IDX_CTRL_FOUR = 8'h53;
    localparam logic [7:0] IDX_AUX_CTRL  = 8'h54;
    localparam logic [7:0] IDX_SLOT_BASE = 8'h40;
    localparam logic [7:0] IDX_RESULT    = 8'h58;
    localparam logic [7:0] IDX_CHAN_SEL  = 8'h59;
    localparam logic [7:0] IDX_COUNT     = 8'h5A;
    localparam logic [7:0] IDX_IRQ_STAT  = 8'h5F;
    localparam logic [7:0] IDX_IRQ_MASK  = 8'h60;
    localparam int NUM_SLOTS = 8;
    localparam int NUM_GP    = 12;
    localparam int CODE_W    = 10;
    localparam int COUNT_W   = 16;
    // channel numbers
    localparam logic [4:0] CH_GP_FIRST = 5'h0A;
    localparam logic [4:0] CH_GP_LAST  = 5'h15;
    localparam logic [4:0] CH_SUPPLY   = 5'h16;
    localparam logic [4:0] CH_CHARGE   = 5'h18;
    localparam logic [4:0] CH_BACKUP   = 5'h19;
    localparam logic [4:0] CH_BATDET   = 5'h1A;
    // aux control bit positions
    localparam int BIT_SUPPLY = 0;
    localparam int BIT_CHARGE = 1;
    localparam int BIT_BACKUP = 2;
    localparam int BIT_BATDET = 3;
    // control one bit positions
    localparam int BIT_PEN_EN = 0;
    localparam int BIT_CC_CLR = 1;
    // irq status bit positions
    localparam int BIT_IRQ_PEN  = 1;
    localparam int BIT_IRQ_CONV = 0;
    localparam int IRQ_W = 3;
    // slot field layout: [4:0] channel, [7:5] bias
    localparam int SLOT_W  = 8;
    localparam int BIAS_LO = 5;
    localparam logic [2:0] BIAS_NONE    = 3'h0;
    localparam logic [2:0] BIAS_X_POS   = 3'h1;
    localparam logic [2:0] BIAS_Y_POS   = 3'h2;
    localparam logic [2:0] BIAS_CONTACT = 3'h3;
    localparam logic [9:0] CODE_ZERO = 10'h000;
    localparam logic [9:0] CODE_FULL = 10'h3FF;
    localparam logic [31:0] RD_ZERO  = 32'h0000_0000;
endpackage

// ==== design/adc_readout.sv ====
// adc_readout: register side of the adc channel select and readout
// assumes the analog front end supplies raw codes and integrator steps
//
// Our own choices: the APB register port and the register offsets.
`timescale 1ns/10ps
module adc_readout
    import adc_readout_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        nrst,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // analog front end
    input  wire logic        convDone,
    input  wire logic [9:0]  rawCode,
    input  wire logic        penSense,
    input  wire logic        ccStep,
    input  wire logic        ccUp,
    // analog controls
    output logic [4:0]       chanSel,
    output logic [2:0]       biasSel,
    output logic [11:0]      gainSel,
    output logic [3:0]       senseEn,
    output logic             penBiasEn,
    output logic             chipIrqOut
);
    logic        rstMeta;
    logic        rstSync;
    logic [7:0]  ctrlOne_reg;
    logic [7:0]  ctrlThree_reg;
    logic [7:0]  ctrlFour_reg;
    logic [7:0]  auxCtrl_reg;
    logic [2:0]  slotIdx_reg;
    logic [SLOT_W-1:0] slot_reg [NUM_SLOTS];
    logic [9:0]  result_reg;
    logic [15:0] charge_count_reg;
    logic [IRQ_W-1:0] irqStat_reg;
    logic [IRQ_W-1:0] irqMask_reg;
    logic        pready_reg;
    logic [31:0] prdata_reg;
    logic        pslverr_reg;
    logic        irq_reg;

    // reset release through two flops
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rstMeta <= 1'b0;
            rstSync <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rstSync <= rstMeta;
        end
    end

    // bus decode
    wire [7:0] word      = paddr[9:2];
    wire       setupPh   = psel && !penable;
    wire       accessPh  = psel && penable && pready_reg;
    wire       wrAcc     = accessPh && pwrite;
    wire       hitSlot   = (word >= IDX_SLOT_BASE) &&
                           (word < IDX_SLOT_BASE + 8'(NUM_SLOTS));
    wire [2:0] slotWr    = 3'(word - IDX_SLOT_BASE);
    wire       hitCtl    = (word == IDX_CTRL_ONE) || (word == IDX_CTRL_THREE) ||
                           (word == IDX_CTRL_FOUR) || (word == IDX_AUX_CTRL) ||
                           (word == IDX_CHAN_SEL) || (word == IDX_IRQ_MASK);
    wire       hitRo     = (word == IDX_RESULT) || (word == IDX_COUNT) ||
                           (word == IDX_IRQ_STAT);
    wire       mapped    = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00) &&
                           (hitSlot || hitCtl || hitRo);
    // result and count refuse writes; status takes write-one-to-clear
    wire       badAcc    = !mapped ||
                           (pwrite && hitRo && (word != IDX_IRQ_STAT));
    wire       wrOk      = wrAcc && !badAcc;

    // current slot drives the analog mux
    wire [SLOT_W-1:0] curSlot = slot_reg[slotIdx_reg];
    wire [4:0]  curChan = curSlot[BIAS_LO-1:0];
    wire [2:0]  curBias = curSlot[SLOT_W-1:BIAS_LO];

    // optional channel gating
    wire chanOff = ((curChan == CH_SUPPLY) && !auxCtrl_reg[BIT_SUPPLY]) ||
                   ((curChan == CH_CHARGE) && !auxCtrl_reg[BIT_CHARGE]) ||
                   ((curChan == CH_BACKUP) && !auxCtrl_reg[BIT_BACKUP]) ||
                   ((curChan == CH_BATDET) && !auxCtrl_reg[BIT_BATDET]);
    // codes pass straight; signed and scaled forms are made in the front end
    wire [9:0] codeNext = chanOff ? CODE_ZERO : rawCode;

    wire [15:0] countNext = ccUp ? charge_count_reg + 16'h0001
                                 : charge_count_reg - 16'h0001;
    wire penEvent  = ctrlOne_reg[BIT_PEN_EN] && penSense;
    wire [IRQ_W-1:0] irqSet = {1'b0, penEvent, convDone};
    wire [IRQ_W-1:0] irqClr = (wrOk && word == IDX_IRQ_STAT) ? pwdata[IRQ_W-1:0]
                                                              : '0;
    wire [IRQ_W-1:0] irqNext = (irqStat_reg & ~irqClr) | irqSet;

    logic [31:0] rdMux;
    always_comb begin
        rdMux = RD_ZERO;
        if (hitSlot)
            rdMux = {24'h000000, slot_reg[slotWr]};
        else
            case (word)
                IDX_CTRL_ONE:   rdMux = {24'h000000, ctrlOne_reg};
                IDX_CTRL_THREE: rdMux = {24'h000000, ctrlThree_reg};
                IDX_CTRL_FOUR:  rdMux = {24'h000000, ctrlFour_reg};
                IDX_AUX_CTRL:   rdMux = {24'h000000, auxCtrl_reg};
                IDX_CHAN_SEL:   rdMux = {29'h00000000, slotIdx_reg};
                IDX_RESULT:     rdMux = {22'h000000, result_reg};
                IDX_COUNT:      rdMux = {16'h0000, charge_count_reg};
                IDX_IRQ_STAT:   rdMux = {29'h00000000, irqStat_reg};
                IDX_IRQ_MASK:   rdMux = {29'h00000000, irqMask_reg};
                default:        rdMux = RD_ZERO;
            endcase
    end

    // apb answer: one wait state, ready on the second access cycle
    always_ff @(posedge clk or negedge rstSync) begin
        if (!rstSync) begin
            pready_reg  <= 1'b0;
            prdata_reg  <= RD_ZERO;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg  <= psel && penable && !pready_reg;
            pslverr_reg <= psel && penable && !pready_reg && badAcc;
            prdata_reg  <= (psel && penable && !pready_reg && !pwrite && mapped) ? rdMux
                                                                                 : RD_ZERO;
        end
    end

    // control registers
    always_ff @(posedge clk or negedge rstSync) begin
        if (!rstSync) begin
            ctrlOne_reg   <= 8'h00;
            ctrlThree_reg <= 8'h00;
            ctrlFour_reg  <= 8'h00;
            auxCtrl_reg   <= 8'h00;
            slotIdx_reg   <= 3'h0;
            irqMask_reg   <= '0;
        end else if (wrOk) begin
            if (word == IDX_CTRL_ONE)   ctrlOne_reg   <= pwdata[7:0];
            if (word == IDX_CTRL_THREE) ctrlThree_reg <= pwdata[7:0];
            if (word == IDX_CTRL_FOUR)  ctrlFour_reg  <= pwdata[7:0];
            if (word == IDX_AUX_CTRL)   auxCtrl_reg   <= pwdata[7:0];
            if (word == IDX_CHAN_SEL)   slotIdx_reg   <= pwdata[2:0];
            if (word == IDX_IRQ_MASK)   irqMask_reg   <= pwdata[IRQ_W-1:0];
        end else if (ctrlOne_reg[BIT_CC_CLR]) begin
            ctrlOne_reg[BIT_CC_CLR] <= 1'b0;
        end
    end

    // slot registers hold channel and bias together
    genvar gi;
    generate
        for (gi = 0; gi < NUM_SLOTS; gi++) begin : gSlot
            always_ff @(posedge clk or negedge rstSync) begin
                if (!rstSync)
                    slot_reg[gi] <= 8'h00;
                else if (wrOk && hitSlot && slotWr == 3'(gi))
                    slot_reg[gi] <= pwdata[SLOT_W-1:0];
            end
        end
    endgenerate

    // result, counter, status
    always_ff @(posedge clk or negedge rstSync) begin
        if (!rstSync) begin
            result_reg       <= CODE_ZERO;
            charge_count_reg <= 16'h0000;
            irqStat_reg      <= '0;
            irq_reg          <= 1'b0;
        end else begin
            if (convDone)
                result_reg <= codeNext;
            if (ctrlOne_reg[BIT_CC_CLR])
                charge_count_reg <= 16'h0000;
            else if (ccStep)
                charge_count_reg <= countNext;
            irqStat_reg <= irqNext;
            irq_reg     <= |(irqNext & ~irqMask_reg);
        end
    end

    // analog controls
    always_ff @(posedge clk or negedge rstSync) begin
        if (!rstSync) begin
            chanSel   <= 5'h00;
            biasSel   <= BIAS_NONE;
            gainSel   <= 12'h000;
            senseEn   <= 4'h0;
            penBiasEn <= 1'b0;
        end else begin
            chanSel   <= curChan;
            biasSel   <= curBias;
            gainSel   <= {ctrlFour_reg[3:0], ctrlThree_reg};
            senseEn   <= auxCtrl_reg[3:0];
            penBiasEn <= ctrlOne_reg[BIT_PEN_EN];
        end
    end

    assign pready     = pready_reg;
    assign prdata     = prdata_reg;
    assign pslverr    = pslverr_reg;
    assign chipIrqOut = irq_reg;

    // assertions
    property p_pen_flag;
        @(posedge clk) disable iff (!rstSync)
        (ctrlOne_reg[BIT_PEN_EN] && penSense) |=> irqStat_reg[BIT_IRQ_PEN];
    endproperty
    a_pen_flag: assert property (p_pen_flag) else $error("pen flag not set");

    property p_irq_out;
        @(posedge clk) disable iff (!rstSync)
        ##1 chipIrqOut == |(irqStat_reg & ~$past(irqMask_reg));
    endproperty
    a_irq_out: assert property (p_irq_out) else $error("irq output wrong");

    property p_pen_bias;
        @(posedge clk) disable iff (!rstSync)
        ##1 penBiasEn == $past(ctrlOne_reg[BIT_PEN_EN]);
    endproperty
    a_pen_bias: assert property (p_pen_bias) else $error("pen bias wrong");

    property p_off_zero;
        @(posedge clk) disable iff (!rstSync)
        (convDone && chanOff) |=> result_reg == CODE_ZERO;
    endproperty
    a_off_zero: assert property (p_off_zero) else $error("disabled channel code");

    sequence s_supply_on;
        convDone && curChan == CH_SUPPLY && auxCtrl_reg[BIT_SUPPLY];
    endsequence
    property p_supply_gate;
        @(posedge clk) disable iff (!rstSync)
        s_supply_on |=> result_reg == $past(rawCode);
    endproperty
    a_supply_gate: assert property (p_supply_gate) else $error("supply code lost");

    sequence s_charge_on;
        convDone && curChan == CH_CHARGE && auxCtrl_reg[BIT_CHARGE];
    endsequence
    property p_charge_gate;
        @(posedge clk) disable iff (!rstSync)
        s_charge_on |=> result_reg == $past(rawCode);
    endproperty
    a_charge_gate: assert property (p_charge_gate) else $error("charge code lost");

    sequence s_backup_on;
        convDone && curChan == CH_BACKUP && auxCtrl_reg[BIT_BACKUP];
    endsequence
    property p_backup_gate;
        @(posedge clk) disable iff (!rstSync)
        s_backup_on |=> result_reg == $past(rawCode);
    endproperty
    a_backup_gate: assert property (p_backup_gate) else $error("backup code lost");

    sequence s_batdet_on;
        convDone && curChan == CH_BATDET && auxCtrl_reg[BIT_BATDET];
    endsequence
    property p_batdet_gate;
        @(posedge clk) disable iff (!rstSync)
        s_batdet_on |=> result_reg == $past(rawCode);
    endproperty
    a_batdet_gate: assert property (p_batdet_gate) else $error("detect code lost");

    sequence s_gp_conv;
        convDone && curChan >= CH_GP_FIRST && curChan <= CH_GP_LAST;
    endsequence
    property p_gp_pass;
        @(posedge clk) disable iff (!rstSync)
        s_gp_conv |=> result_reg == $past(rawCode);
    endproperty
    a_gp_pass: assert property (p_gp_pass) else $error("input code lost");

    property p_count;
        @(posedge clk) disable iff (!rstSync)
        (ccStep && ccUp && !ctrlOne_reg[BIT_CC_CLR])
            |=> charge_count_reg == $past(charge_count_reg) + 16'h0001;
    endproperty
    a_count: assert property (p_count) else $error("count did not step");

    property p_count_down;
        @(posedge clk) disable iff (!rstSync)
        (ccStep && !ccUp && !ctrlOne_reg[BIT_CC_CLR])
            |=> charge_count_reg == $past(charge_count_reg) - 16'h0001;
    endproperty
    a_count_down: assert property (p_count_down) else $error("count did not drop");

    property p_count_clr;
        @(posedge clk) disable iff (!rstSync)
        ctrlOne_reg[BIT_CC_CLR] |=> charge_count_reg == 16'h0000 && !ctrlOne_reg[BIT_CC_CLR];
    endproperty
    a_count_clr: assert property (p_count_clr) else $error("count not cleared");

    property p_gain;
        @(posedge clk) disable iff (!rstSync)
        ##1 gainSel == {$past(ctrlFour_reg[3:0]), $past(ctrlThree_reg)};
    endproperty
    a_gain: assert property (p_gain) else $error("gain bits wrong");

    property p_bias;
        @(posedge clk) disable iff (!rstSync)
        ##1 biasSel == $past(curBias);
    endproperty
    a_bias: assert property (p_bias) else $error("bias not from slot");

    property p_chan;
        @(posedge clk) disable iff (!rstSync)
        ##1 chanSel == $past(curChan);
    endproperty
    a_chan: assert property (p_chan) else $error("channel not from slot");

    property p_sense_en;
        @(posedge clk) disable iff (!rstSync)
        ##1 senseEn == $past(auxCtrl_reg[BIT_BATDET:BIT_SUPPLY]);
    endproperty
    a_sense_en: assert property (p_sense_en) else $error("enables wrong");

    sequence s_access;
        psel && penable && !pready;
    endsequence
    property p_stat_ro;
        @(posedge clk) disable iff (!rstSync)
        s_access ##1 (wrOk && word == IDX_IRQ_STAT)
            |-> !pslverr ##1 ((irqStat_reg & ~$past(irqStat_reg | irqSet)) == '0);
    endproperty
    a_stat_ro: assert property (p_stat_ro) else $error("status bit set by write");

    sequence s_clear_pen;
        wrOk && word == IDX_IRQ_STAT && pwdata[BIT_IRQ_PEN] && !penEvent;
    endsequence
    property p_stat_clr;
        @(posedge clk) disable iff (!rstSync)
        s_clear_pen |=> !irqStat_reg[BIT_IRQ_PEN];
    endproperty
    a_stat_clr: assert property (p_stat_clr) else $error("pen flag not cleared");

    property p_setup_idle;
        @(posedge clk) disable iff (!rstSync)
        setupPh |-> !pready && !pslverr;
    endproperty
    a_setup_idle: assert property (p_setup_idle) else $error("answer in setup phase");

    property p_ready_wait;
        @(posedge clk) disable iff (!rstSync)
        s_access |=> pready;
    endproperty
    a_ready_wait: assert property (p_ready_wait) else $error("ready late");
endmodule

// ==== bench/host_apb_master.sv ====
// host_apb_master: host side apb requester for the readout block
// assumes one clock; requests change only right after a rising edge
`timescale 1ns/10ps
module host_apb_master (
    // clock
    input  wire logic        clk,
    // apb request
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [11:0]      paddr,
    output logic [31:0]      pwdata,
    // apb answer
    input  wire logic        pready,
    input  wire logic [31:0] prdata,
    input  wire logic        pslverr
);
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h0000_0000;
    end

    // one whole transfer; the host owns sequencing and delays
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        paddr   <= ~a;
        pwdata  <= ~d;
    endtask
endmodule

// ==== bench/tb_adc_readout.sv ====
// tb_adc_readout: self-checking bench for the adc readout block
// assumes the host model drives apb; bench drives the front end
`timescale 1ns/10ps
module tb_adc_readout
    import adc_readout_pkg::*;
();
    logic        clk, nrst, psel, penable, pwrite, pready, pslverr;
    logic        convDone, penSense, ccStep, ccUp, penBiasEn, chipIrqOut, er;
    logic [11:0] paddr, gainSel, g;
    logic [31:0] pwdata, prdata, rd;
    logic [9:0]  rawCode, raw;
    logic [4:0]  chanSel, ch;
    logic [2:0]  biasSel, b;
    logic [3:0]  senseEn, en;
    logic [4:0]  chTab [5];
    int          mismatches, nCompared, n, m;

    always #50 clk = ~clk;

    host_apb_master host_apb_master_inst (.clk(clk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr));

    adc_readout adc_readout_inst (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .convDone(convDone), .rawCode(rawCode),
        .penSense(penSense), .ccStep(ccStep), .ccUp(ccUp), .chanSel(chanSel),
        .biasSel(biasSel), .gainSel(gainSel), .senseEn(senseEn),
        .penBiasEn(penBiasEn), .chipIrqOut(chipIrqOut));

    function automatic logic [11:0] ba(input logic [7:0] idx);
        return {2'b00, idx, 2'b00};
    endfunction

    function automatic logic [31:0] expRes(input logic [4:0] c, input logic [3:0] e,
                                           input logic [9:0] r);
        logic on;
        on = 1'b1;
        if (c == CH_SUPPLY) on = e[BIT_SUPPLY];
        if (c == CH_CHARGE) on = e[BIT_CHARGE];
        if (c == CH_BACKUP) on = e[BIT_BACKUP];
        if (c == CH_BATDET) on = e[BIT_BATDET];
        return on ? {22'h000000, r} : RD_ZERO;
    endfunction

    task automatic chkW(input logic [31:0] got, input logic [31:0] exp);
        nCompared++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chkB(input logic got, input logic exp);
        nCompared++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t: flag %b expected %b", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        host_apb_master_inst.xfer(1'b1, a, d, rd, er);
        chkB(er, 1'b0);
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        host_apb_master_inst.xfer(1'b0, a, 32'h0000_0000, rd, er);
        chkW(rd, e);
    endtask

    task automatic conv(input logic [9:0] r);
        @(posedge clk);
        convDone <= 1'b1;
        rawCode  <= r;
        @(posedge clk);
        convDone <= 1'b0;
        rawCode  <= ~r;
        repeat (2) @(posedge clk);
    endtask

    task automatic step(input logic up);
        @(posedge clk);
        ccStep <= 1'b1;
        ccUp   <= up;
        @(posedge clk);
        ccStep <= 1'b0;
        ccUp   <= ~up;
    endtask

    task automatic endOfTest;
        if (mismatches == 0 && nCompared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        #2000000;
        mismatches++;
        endOfTest;
    end

    initial begin
        clk = 1'b0;
        nrst = 1'b0;
        convDone = 1'b0;
        rawCode = 10'h000;
        penSense = 1'b0;
        ccStep = 1'b0;
        ccUp = 1'b0;
        chTab = '{CH_SUPPLY, CH_CHARGE, CH_BACKUP, CH_BATDET, CH_GP_LAST};
        void'($urandom(60));
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        rdc(ba(IDX_IRQ_STAT), RD_ZERO);
        for (int i = 0; i < 10; i++) begin
            g = (i == 0) ? 12'h000 : (i == 1) ? 12'hFFF : 12'($urandom);
            wr(ba(IDX_CTRL_THREE), {24'h000000, g[7:0]});
            wr(ba(IDX_CTRL_FOUR), {28'h0000000, g[11:8]});
            repeat (2) @(posedge clk);
            chkW({20'h00000, gainSel}, {20'h00000, g});
        end
        for (int k = 0; k < 10; k++) begin
            ch = chTab[k / 2];
            en = (k % 2 == 1 && k < 8) ? 4'(1 << (k / 2)) : 4'h0;
            raw = (k < 2) ? CODE_FULL : (k < 6) ? 10'h200 : 10'($urandom);
            wr(ba(IDX_AUX_CTRL), {28'h0000000, en});
            wr(ba(IDX_SLOT_BASE), {24'h000000, BIAS_NONE, ch});
            wr(ba(IDX_CHAN_SEL), RD_ZERO);
            repeat (2) @(posedge clk);
            chkW({28'h0000000, senseEn}, {28'h0000000, en});
            conv(raw);
            rdc(ba(IDX_RESULT), expRes(ch, en, raw));
        end
        for (int i = 0; i < NUM_SLOTS; i++) begin
            ch = 5'(CH_GP_FIRST + 5'(i));
            b = (i < 4) ? 3'(i) : BIAS_NONE;
            wr(ba(8'(IDX_SLOT_BASE + 8'(i))), {24'h000000, b, ch});
            wr(ba(IDX_CHAN_SEL), 32'(i));
            repeat (2) @(posedge clk);
            chkW({27'h0, chanSel}, {27'h0, ch});
            chkW({29'h0, biasSel}, {29'h0, b});
            raw = i[0] ? CODE_FULL : CODE_ZERO;
            conv(raw);
            rdc(ba(IDX_RESULT), {22'h000000, raw});
        end
        wr(ba(IDX_CTRL_ONE), RD_ZERO);
        penSense <= 1'b1;
        repeat (3) @(posedge clk);
        host_apb_master_inst.xfer(1'b0, ba(IDX_IRQ_STAT), RD_ZERO, rd, er);
        chkB(rd[BIT_IRQ_PEN], 1'b0);
        wr(ba(IDX_IRQ_STAT), 32'h0000_0003);
        rdc(ba(IDX_IRQ_STAT), RD_ZERO);
        chkB(chipIrqOut, 1'b0);
        wr(ba(IDX_CTRL_ONE), 32'h0000_0001);
        repeat (3) @(posedge clk);
        chkB(penBiasEn, 1'b1);
        host_apb_master_inst.xfer(1'b0, ba(IDX_IRQ_STAT), RD_ZERO, rd, er);
        chkB(rd[BIT_IRQ_PEN], 1'b1);
        chkB(chipIrqOut, 1'b1);
        wr(ba(IDX_IRQ_MASK), 32'h0000_0007);
        repeat (2) @(posedge clk);
        chkB(chipIrqOut, 1'b0);
        wr(ba(IDX_IRQ_STAT), 32'h0000_0002);
        rdc(ba(IDX_IRQ_STAT), 32'h0000_0002);
        penSense <= 1'b0;
        wr(ba(IDX_IRQ_STAT), 32'h0000_0002);
        rdc(ba(IDX_IRQ_STAT), RD_ZERO);
        wr(ba(IDX_CTRL_ONE), 32'h0000_0002);
        n = $urandom % 20;
        m = n + 1 + $urandom % 5;
        repeat (n) step(1'b1);
        repeat (m) step(1'b0);
        repeat (2) @(posedge clk);
        rdc(ba(IDX_COUNT), {16'h0000, 16'(n - m)});
        wr(ba(IDX_CTRL_ONE), 32'h0000_0002);
        rdc(ba(IDX_COUNT), RD_ZERO);
        host_apb_master_inst.xfer(1'b1, ba(IDX_RESULT), 32'h0000_03FF, rd, er);
        chkB(er, 1'b1);
        host_apb_master_inst.xfer(1'b0, 12'hFFC, RD_ZERO, rd, er);
        chkB(er, 1'b1);
        chkW(rd, RD_ZERO);
        wr(ba(IDX_AUX_CTRL), RD_ZERO);
        endOfTest;
    end
endmodule
